// >>> inc/charger_cfg_pkg.sv
package charger_cfg_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // Register offsets
  localparam logic [7:0] OFF_TIMER_TASK = 8'h02;
  localparam logic [7:0] OFF_EN_SET = 8'h04;
  localparam logic [7:0] OFF_EN_CLR = 8'h05;
  localparam logic [7:0] OFF_INH_SET = 8'h06;
  localparam logic [7:0] OFF_INH_CLR = 8'h07;
  localparam logic [7:0] OFF_ICHG_HI = 8'h08;
  localparam logic [7:0] OFF_ICHG_LO = 8'h09;
  localparam logic [7:0] OFF_IDIS_HI = 8'h0a;
  localparam logic [7:0] OFF_IDIS_LO = 8'h0b;
  localparam logic [7:0] OFF_VTERM_NORM = 8'h0c;
  localparam logic [7:0] OFF_VTERM_WARM = 8'h0d;
  localparam logic [7:0] OFF_PRECHG = 8'h0e;
  localparam logic [7:0] OFF_ITERM = 8'h0f;
  localparam logic [7:0] OFF_COLD_HI = 8'h10;
  localparam logic [7:0] OFF_COLD_LO = 8'h11;
  localparam logic [7:0] OFF_COOL_HI = 8'h12;
  localparam logic [7:0] OFF_COOL_LO = 8'h13;
  localparam logic [7:0] OFF_WARM_HI = 8'h14;
  localparam logic [7:0] OFF_WARM_LO = 8'h15;
  localparam logic [7:0] OFF_HOT_HI = 8'h16;
  localparam logic [7:0] OFF_HOT_LO = 8'h17;

  // Field positions
  localparam int BIT_ON = 0;
  localparam int BIT_FULL_COOL = 1;
  localparam int BIT_RECH_INH = 0;
  localparam int BIT_NTC_IGN = 1;
  localparam int BIT_TASK = 0;

  // Reset values
  localparam logic [7:0] RST_ICHG_HI = 8'h08;
  localparam logic [0:0] RST_ICHG_LO = 1'h0;
  localparam logic [7:0] RST_IDIS_HI = 8'hcf;
  localparam logic [0:0] RST_IDIS_LO = 1'h1;
  localparam logic [3:0] RST_VTERM = 4'h2;
  localparam logic [0:0] RST_SEL = 1'h0;
  localparam logic [7:0] RST_COLD_HI = 8'hbb;
  localparam logic [1:0] RST_COLD_LO = 2'h1;
  localparam logic [7:0] RST_COOL_HI = 8'ha4;
  localparam logic [1:0] RST_COOL_LO = 2'h2;
  localparam logic [7:0] RST_WARM_HI = 8'h54;
  localparam logic [1:0] RST_WARM_LO = 2'h1;
  localparam logic [7:0] RST_HOT_HI = 8'h3b;
  localparam logic [1:0] RST_HOT_LO = 2'h1;

  // Highest legal termination voltage code; above maps to default
  localparam logic [3:0] VTERM_MAX_CODE = 4'hd;

  typedef struct packed {
    logic charge_on;
    logic full_current_when_cool;
    logic recharge_inhibit;
    logic thermistor_ignore;
    logic precharge_level;
    logic term_current_level;
    logic [8:0] charge_current_code;
    logic [8:0] discharge_limit_code;
    logic [3:0] normal_term_voltage;
    logic [3:0] warm_term_voltage;
  } charge_cfg_t;

  typedef struct packed {
    logic [9:0] cold;
    logic [9:0] cool;
    logic [9:0] warm;
    logic [9:0] hot;
  } ntc_levels_t;

  typedef enum logic [1:0] {ACC_IDLE, ACC_WRITE, ACC_READ} acc_kind_t;
endpackage : charger_cfg_pkg

// >>> hw/charger_config_registers.sv
// Contract
// - Task write one restarts both safety timers
// - Set bit0 write one enables charging
// - Clear bit0 write one disables charging
// - Bit1 pair selects full cool current
// - Bit0 inhibit pair controls recharge inhibition
// - Bit1 inhibit pair ignores thermistor limits
// - Charge current upper bits reset 0x08
// - Charge current lsb separate, resets zero
// - Discharge limit resets 0xcf and 1
// - Termination voltage code, reset two
// - Codes 14 and 15 act as default
// - Warm termination code, same encoding
// - Precharge level select resets zero
// - Termination current select resets zero
// - Cold threshold resets 0xbb, 1
// - Cool threshold resets 0xa4, 2
// - Warm threshold resets 0x54, 1
// - Hot threshold resets 0x3b, 1
// - Recharge only when not inhibited
`timescale 1ns/1ps
module charger_config_registers
  import charger_cfg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  // Register port from the serial interface
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [DATA_W-1:0] wdata_in,
  output logic [DATA_W-1:0] rdata_out,
  output logic rvalid_out,
  // Charger state machine
  input wire logic recharge_needed_in,
  output logic timer_restart_task_out,
  output logic recharge_start_out,
  output charge_cfg_t cfg_out,
  output ntc_levels_t ntc_out
);

  logic on_q, cool_q, inh_q, ign_q, tri_q, iterm_q;
  logic [7:0] ichg_hi_q, idis_hi_q;
  logic ichg_lo_q, idis_lo_q;
  logic [3:0] vnorm_q, vwarm_q;
  logic [7:0] cold_hi_q, cool_hi_q, warm_hi_q, hot_hi_q;
  logic [1:0] cold_lo_q, cool_lo_q, warm_lo_q, hot_lo_q;
  logic [DATA_W-1:0] rdata_d;

  // Decode
  wire logic w_task = wr_en_in && addr_in == OFF_TIMER_TASK;
  wire logic w_en_s = wr_en_in && addr_in == OFF_EN_SET;
  wire logic w_en_c = wr_en_in && addr_in == OFF_EN_CLR;
  wire logic w_in_s = wr_en_in && addr_in == OFF_INH_SET;
  wire logic w_in_c = wr_en_in && addr_in == OFF_INH_CLR;
  wire logic task_hit = w_task && wdata_in[BIT_TASK];
  wire logic [7:0] en_rd = {6'h00, cool_q, on_q};
  wire logic [7:0] inh_rd = {6'h00, ign_q, inh_q};

  // Terminal voltage codes 14 and 15 behave like the default
  function automatic logic [3:0] vterm_eff(input logic [3:0] c);
    vterm_eff = (c > VTERM_MAX_CODE) ? RST_VTERM : c;
  endfunction : vterm_eff

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      on_q <= 1'b0;
      cool_q <= 1'b0;
      inh_q <= 1'b0;
      ign_q <= 1'b0;
    end else begin
      if (w_en_s && wdata_in[BIT_ON]) begin
        on_q <= 1'b1;
      end else if (w_en_c && wdata_in[BIT_ON]) begin
        on_q <= 1'b0;
      end
      if (w_en_s && wdata_in[BIT_FULL_COOL]) begin
        cool_q <= 1'b1;
      end else if (w_en_c && wdata_in[BIT_FULL_COOL]) begin
        cool_q <= 1'b0;
      end
      if (w_in_s && wdata_in[BIT_RECH_INH]) begin
        inh_q <= 1'b1;
      end else if (w_in_c && wdata_in[BIT_RECH_INH]) begin
        inh_q <= 1'b0;
      end
      if (w_in_s && wdata_in[BIT_NTC_IGN]) begin
        ign_q <= 1'b1;
      end else if (w_in_c && wdata_in[BIT_NTC_IGN]) begin
        ign_q <= 1'b0;
      end
    end
  end

  a_cool_zero_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && (addr_in == OFF_EN_SET || addr_in == OFF_EN_CLR) && !wdata_in[BIT_FULL_COOL]
    |=> $stable(cool_q))
    else $error("full cool current changed by zero write");
  a_inhibit_zero_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && (addr_in == OFF_INH_SET || addr_in == OFF_INH_CLR) && !wdata_in[BIT_RECH_INH]
    |=> $stable(inh_q))
    else $error("recharge inhibit changed by zero write");
  a_ignore_zero_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && (addr_in == OFF_INH_SET || addr_in == OFF_INH_CLR) && !wdata_in[BIT_NTC_IGN]
    |=> $stable(ign_q))
    else $error("thermistor ignore changed by zero write");

  // Plain read/write configuration
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ichg_hi_q <= RST_ICHG_HI;
      ichg_lo_q <= RST_ICHG_LO;
      idis_hi_q <= RST_IDIS_HI;
      idis_lo_q <= RST_IDIS_LO;
      vnorm_q <= RST_VTERM;
      vwarm_q <= RST_VTERM;
      tri_q <= RST_SEL;
      iterm_q <= RST_SEL;
      cold_hi_q <= RST_COLD_HI;
      cold_lo_q <= RST_COLD_LO;
      cool_hi_q <= RST_COOL_HI;
      cool_lo_q <= RST_COOL_LO;
      warm_hi_q <= RST_WARM_HI;
      warm_lo_q <= RST_WARM_LO;
      hot_hi_q <= RST_HOT_HI;
      hot_lo_q <= RST_HOT_LO;
    end else if (wr_en_in) begin
      unique case (addr_in)
        OFF_ICHG_HI: ichg_hi_q <= wdata_in;
        OFF_ICHG_LO: ichg_lo_q <= wdata_in[0];
        OFF_IDIS_HI: idis_hi_q <= wdata_in;
        OFF_IDIS_LO: idis_lo_q <= wdata_in[0];
        OFF_VTERM_NORM: vnorm_q <= wdata_in[3:0];
        OFF_VTERM_WARM: vwarm_q <= wdata_in[3:0];
        OFF_PRECHG: tri_q <= wdata_in[0];
        OFF_ITERM: iterm_q <= wdata_in[0];
        OFF_COLD_HI: cold_hi_q <= wdata_in;
        OFF_COLD_LO: cold_lo_q <= wdata_in[1:0];
        OFF_COOL_HI: cool_hi_q <= wdata_in;
        OFF_COOL_LO: cool_lo_q <= wdata_in[1:0];
        OFF_WARM_HI: warm_hi_q <= wdata_in;
        OFF_WARM_LO: warm_lo_q <= wdata_in[1:0];
        OFF_HOT_HI: hot_hi_q <= wdata_in;
        OFF_HOT_LO: hot_lo_q <= wdata_in[1:0];
        default: ;
      endcase
    end
  end

  sequence s_reset_ends;
    !rst_n_in ##1 rst_n_in;
  endsequence

  a_charge_reset: assert property (@(posedge ref_clk_in)
    s_reset_ends |-> ichg_hi_q == RST_ICHG_HI)
    else $error("charge current upper reset wrong");
  a_charge_lsb_reset: assert property (@(posedge ref_clk_in)
    s_reset_ends |-> ichg_lo_q == RST_ICHG_LO)
    else $error("charge current lsb reset wrong");
  a_discharge_reset: assert property (@(posedge ref_clk_in)
    s_reset_ends |-> idis_hi_q == RST_IDIS_HI && idis_lo_q == RST_IDIS_LO)
    else $error("discharge limit reset wrong");
  a_vterm_reset: assert property (@(posedge ref_clk_in)
    s_reset_ends |-> vnorm_q == RST_VTERM)
    else $error("normal termination code reset wrong");
  a_warm_vterm_reset: assert property (@(posedge ref_clk_in)
    s_reset_ends |-> vwarm_q == RST_VTERM)
    else $error("warm termination code reset wrong");
  a_trickle_reset: assert property (@(posedge ref_clk_in)
    s_reset_ends |-> tri_q == RST_SEL)
    else $error("precharge level reset wrong");
  a_iterm_reset: assert property (@(posedge ref_clk_in)
    s_reset_ends |-> iterm_q == RST_SEL)
    else $error("termination current reset wrong");
  a_cold_reset: assert property (@(posedge ref_clk_in)
    s_reset_ends |-> cold_hi_q == RST_COLD_HI && cold_lo_q == RST_COLD_LO)
    else $error("cold threshold reset wrong");
  a_cool_reset: assert property (@(posedge ref_clk_in)
    s_reset_ends |-> cool_hi_q == RST_COOL_HI && cool_lo_q == RST_COOL_LO)
    else $error("cool threshold reset wrong");
  a_warm_reset: assert property (@(posedge ref_clk_in)
    s_reset_ends |-> warm_hi_q == RST_WARM_HI && warm_lo_q == RST_WARM_LO)
    else $error("warm threshold reset wrong");
  a_hot_reset: assert property (@(posedge ref_clk_in)
    s_reset_ends |-> hot_hi_q == RST_HOT_HI && hot_lo_q == RST_HOT_LO)
    else $error("hot threshold reset wrong");

  a_charge_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_ICHG_HI |=> ichg_hi_q == $past(wdata_in))
    else $error("charge current upper not written");
  a_charge_lsb_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_ICHG_LO |=> ichg_lo_q == $past(wdata_in[0]))
    else $error("charge current lsb not written");
  a_discharge_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_IDIS_HI |=> idis_hi_q == $past(wdata_in))
    else $error("discharge limit upper not written");
  a_vterm_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_VTERM_NORM |=> vnorm_q == $past(wdata_in[3:0]))
    else $error("normal termination code not written");
  a_warm_vterm_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_VTERM_WARM |=> vwarm_q == $past(wdata_in[3:0]))
    else $error("warm termination code not written");
  a_trickle_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_PRECHG |=> tri_q == $past(wdata_in[0]))
    else $error("precharge level not written");
  a_iterm_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_ITERM |=> iterm_q == $past(wdata_in[0]))
    else $error("termination current not written");
  a_cold_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_COLD_LO |=> cold_lo_q == $past(wdata_in[1:0]))
    else $error("cold threshold lsb not written");
  a_cool_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_COOL_LO |=> cool_lo_q == $past(wdata_in[1:0]))
    else $error("cool threshold lsb not written");
  a_warm_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_WARM_LO |=> warm_lo_q == $past(wdata_in[1:0]))
    else $error("warm threshold lsb not written");
  a_hot_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_HOT_LO |=> hot_lo_q == $past(wdata_in[1:0]))
    else $error("hot threshold lsb not written");

  // Read mux; task and unmapped offsets read zero
  always_comb begin
    unique case (addr_in)
      OFF_EN_SET, OFF_EN_CLR: rdata_d = en_rd;
      OFF_INH_SET, OFF_INH_CLR: rdata_d = inh_rd;
      OFF_ICHG_HI: rdata_d = ichg_hi_q;
      OFF_ICHG_LO: rdata_d = {7'h00, ichg_lo_q};
      OFF_IDIS_HI: rdata_d = idis_hi_q;
      OFF_IDIS_LO: rdata_d = {7'h00, idis_lo_q};
      OFF_VTERM_NORM: rdata_d = {4'h0, vnorm_q};
      OFF_VTERM_WARM: rdata_d = {4'h0, vwarm_q};
      OFF_PRECHG: rdata_d = {7'h00, tri_q};
      OFF_ITERM: rdata_d = {7'h00, iterm_q};
      OFF_COLD_HI: rdata_d = cold_hi_q;
      OFF_COLD_LO: rdata_d = {6'h00, cold_lo_q};
      OFF_COOL_HI: rdata_d = cool_hi_q;
      OFF_COOL_LO: rdata_d = {6'h00, cool_lo_q};
      OFF_WARM_HI: rdata_d = warm_hi_q;
      OFF_WARM_LO: rdata_d = {6'h00, warm_lo_q};
      OFF_HOT_HI: rdata_d = hot_hi_q;
      OFF_HOT_LO: rdata_d = {6'h00, hot_lo_q};
      default: rdata_d = 8'h00;
    endcase
  end

  a_task_reads_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && addr_in == OFF_TIMER_TASK |=> rdata_out == '0)
    else $error("task offset read not zero");
  a_enable_readback: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && addr_in == OFF_EN_SET |=> rdata_out[BIT_ON] == $past(on_q))
    else $error("enable read wrong at set offset");
  a_clear_readback: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && addr_in == OFF_EN_CLR |=> rdata_out[BIT_ON] == $past(on_q))
    else $error("enable read wrong at clear offset");
  a_cool_readback: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && (addr_in == OFF_EN_SET || addr_in == OFF_EN_CLR)
    |=> rdata_out[BIT_FULL_COOL] == $past(cool_q))
    else $error("full cool current read wrong");
  a_inhibit_readback: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && (addr_in == OFF_INH_SET || addr_in == OFF_INH_CLR)
    |=> rdata_out[BIT_RECH_INH] == $past(inh_q))
    else $error("recharge inhibit read wrong");
  a_ignore_readback: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_en_in && (addr_in == OFF_INH_SET || addr_in == OFF_INH_CLR)
    |=> rdata_out[BIT_NTC_IGN] == $past(ign_q))
    else $error("thermistor ignore read wrong");

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
      timer_restart_task_out <= 1'b0;
      recharge_start_out <= 1'b0;
      cfg_out <= '0;
      ntc_out <= '0;
    end else begin
      rvalid_out <= rd_en_in;
      if (rd_en_in) begin
        rdata_out <= rdata_d;
      end
      timer_restart_task_out <= task_hit;
      recharge_start_out <= recharge_needed_in && on_q && !inh_q;
      cfg_out.charge_on <= on_q;
      cfg_out.full_current_when_cool <= cool_q;
      cfg_out.recharge_inhibit <= inh_q;
      cfg_out.thermistor_ignore <= ign_q;
      cfg_out.precharge_level <= tri_q;
      cfg_out.term_current_level <= iterm_q;
      cfg_out.charge_current_code <= {ichg_hi_q, ichg_lo_q};
      cfg_out.discharge_limit_code <= {idis_hi_q, idis_lo_q};
      cfg_out.normal_term_voltage <= vterm_eff(vnorm_q);
      cfg_out.warm_term_voltage <= vterm_eff(vwarm_q);
      ntc_out.cold <= {cold_hi_q, cold_lo_q};
      ntc_out.cool <= {cool_hi_q, cool_lo_q};
      ntc_out.warm <= {warm_hi_q, warm_lo_q};
      ntc_out.hot <= {hot_hi_q, hot_lo_q};
    end
  end

  // Assertions
  sequence s_task_write;
    wr_en_in && addr_in == OFF_TIMER_TASK && wdata_in[BIT_TASK];
  endsequence

  sequence s_task_quiet;
    !(wr_en_in && addr_in == OFF_TIMER_TASK && wdata_in[BIT_TASK]);
  endsequence

  a_task_pulse_once: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_task_write ##1 s_task_quiet |-> timer_restart_task_out ##1 !timer_restart_task_out)
    else $error("timer restart pulse wrong");
  a_task_no_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_task_quiet |=> !timer_restart_task_out)
    else $error("timer restart without write of one");
  a_enable_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_EN_SET && wdata_in[BIT_ON] |=> ##1 cfg_out.charge_on)
    else $error("charge enable not set");
  a_enable_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_EN_CLR && wdata_in[BIT_ON] |=> ##1 !cfg_out.charge_on)
    else $error("charge enable not cleared");
  a_enable_zero_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && (addr_in == OFF_EN_SET || addr_in == OFF_EN_CLR) && !wdata_in[BIT_ON]
    |=> $stable(on_q))
    else $error("enable changed by zero write");
  a_cool_select: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_EN_CLR && wdata_in[BIT_FULL_COOL]
    |=> ##1 !cfg_out.full_current_when_cool)
    else $error("full cool current not cleared");
  a_cool_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_EN_SET && wdata_in[BIT_FULL_COOL]
    |=> ##1 cfg_out.full_current_when_cool)
    else $error("full cool current not set");
  a_inhibit_pair: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_INH_SET && wdata_in[BIT_RECH_INH]
    |=> ##1 cfg_out.recharge_inhibit)
    else $error("recharge inhibit not set");
  a_inhibit_clear: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_INH_CLR && wdata_in[BIT_RECH_INH]
    |=> ##1 !cfg_out.recharge_inhibit)
    else $error("recharge inhibit not cleared");
  a_ntc_ignore: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_INH_CLR && wdata_in[BIT_NTC_IGN]
    |=> ##1 !cfg_out.thermistor_ignore)
    else $error("thermistor ignore not cleared");
  a_ntc_set: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_en_in && addr_in == OFF_INH_SET && wdata_in[BIT_NTC_IGN]
    |=> ##1 cfg_out.thermistor_ignore)
    else $error("thermistor ignore not set");
  a_vterm_alias: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    vnorm_q > VTERM_MAX_CODE |=> cfg_out.normal_term_voltage == RST_VTERM)
    else $error("illegal vterm code not mapped");
  a_warm_alias: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    vwarm_q > VTERM_MAX_CODE |=> cfg_out.warm_term_voltage == RST_VTERM)
    else $error("illegal warm vterm code not mapped");
  a_vterm_pass: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    vnorm_q <= VTERM_MAX_CODE |=> cfg_out.normal_term_voltage == $past(vnorm_q))
    else $error("legal vterm code not passed");
  a_recharge_gate: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    inh_q |=> !recharge_start_out)
    else $error("recharge started while inhibited");
  a_recharge_start: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    recharge_needed_in && on_q && !inh_q |=> recharge_start_out)
    else $error("recharge not started");
  a_charge_mirror: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rst_n_in |=> cfg_out.charge_current_code == $past({ichg_hi_q, ichg_lo_q}))
    else $error("charge current code not mirrored");
  a_discharge_mirror: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rst_n_in |=> cfg_out.discharge_limit_code == $past({idis_hi_q, idis_lo_q}))
    else $error("discharge limit code not mirrored");
  a_select_mirror: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rst_n_in |=> cfg_out.precharge_level == $past(tri_q)
    && cfg_out.term_current_level == $past(iterm_q))
    else $error("level selects not mirrored");
  a_cold_mirror: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rst_n_in |=> ntc_out.cold == $past({cold_hi_q, cold_lo_q}))
    else $error("cold threshold not mirrored");
  a_cool_mirror: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rst_n_in |=> ntc_out.cool == $past({cool_hi_q, cool_lo_q}))
    else $error("cool threshold not mirrored");
  a_warm_mirror: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rst_n_in |=> ntc_out.warm == $past({warm_hi_q, warm_lo_q}))
    else $error("warm threshold not mirrored");
  a_hot_mirror: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rst_n_in |=> ntc_out.hot == $past({hot_hi_q, hot_lo_q}))
    else $error("hot threshold not mirrored");

endmodule : charger_config_registers

// >>> tb/charger_host_model.sv
`timescale 1ns/1ps
module charger_host_model
  import charger_cfg_pkg::*;
(
  // Clock
  input wire logic ref_clk_in,
  // Read answer from the register bank
  input wire logic [DATA_W-1:0] rdata_in,
  input wire logic rvalid_in,
  // Register requests
  output logic wr_en_out,
  output logic rd_en_out,
  output logic [ADDR_W-1:0] addr_out,
  output logic [DATA_W-1:0] wdata_out
);
  initial begin
    wr_en_out = 1'b0;
    rd_en_out = 1'b0;
    addr_out = 8'h00;
    wdata_out = 8'h00;
  end

  // Limit code is current in mA over 3.23, rounded
  function automatic logic [8:0] discharge_code(input int ma);
    discharge_code = 9'((ma * 100 + 161) / 323);
  endfunction : discharge_code

  // Released lines show the inverse, not the last value
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk_in);
    #1;
    wr_en_out = 1'b1;
    addr_out = a;
    wdata_out = d;
    @(posedge ref_clk_in);
    #1;
    wr_en_out = 1'b0;
    addr_out = ~a;
    wdata_out = ~d;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge ref_clk_in);
    #1;
    rd_en_out = 1'b1;
    addr_out = a;
    @(posedge ref_clk_in);
    #1;
    rd_en_out = 1'b0;
    addr_out = ~a;
    v = rvalid_in;
    d = rdata_in;
  endtask : read_reg
endmodule : charger_host_model

// >>> tb/tb.sv
`timescale 1ns/1ps
module tb;
  import charger_cfg_pkg::*;
  logic ref_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic recharge_needed_in = 1'b0;
  logic wr_en, rd_en, rvalid, v, pulse, rstart;
  logic [7:0] addr, wdata, rdata, rd;
  logic [8:0] dcode;
  charge_cfg_t cfg;
  ntc_levels_t ntc;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  logic [7:0] rst_tab [20] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h08, 8'h00, 8'hcf, 8'h01,
    8'h02, 8'h02, 8'h00, 8'h00, 8'hbb, 8'h01, 8'ha4, 8'h02, 8'h54, 8'h01, 8'h3b, 8'h01};

  always #2.5 ref_clk_in = ~ref_clk_in;

  charger_config_registers u_dut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en), .rd_en_in(rd_en),
    .addr_in(addr), .wdata_in(wdata), .rdata_out(rdata), .rvalid_out(rvalid),
    .recharge_needed_in(recharge_needed_in), .timer_restart_task_out(pulse),
    .recharge_start_out(rstart), .cfg_out(cfg), .ntc_out(ntc));

  charger_host_model u_host (
    .ref_clk_in(ref_clk_in), .rdata_in(rdata), .rvalid_in(rvalid), .wr_en_out(wr_en),
    .rd_en_out(rd_en), .addr_out(addr), .wdata_out(wdata));

  task automatic tally_and_finish();
    $display("compared %0d mismatched %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : tally_and_finish

  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 4000) begin
      errors++;
      tally_and_finish();
    end
  end

  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_read(input logic [7:0] a, input logic [7:0] exp);
    u_host.read_reg(a, rd, v);
    samples_checked++;
    if (v !== 1'b1 || rd !== exp) begin
      errors++;
      $display("[FAIL] %0t read %h got %h exp %h", $time, a, rd, exp);
    end
  endtask : chk_read

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    u_host.write_reg(a, d);
  endtask : wr

  task automatic settle();
    repeat (2) @(posedge ref_clk_in);
    #1;
  endtask : settle

  initial begin
    repeat (12) @(posedge ref_clk_in);
    #1;
    rst_n_in = 1'b1;
    settle();
    chk_val({1'b0, cfg.charge_current_code}, 10'h010, "ichg");
    chk_val({1'b0, cfg.discharge_limit_code}, 10'h19f, "idis");
    chk_val(ntc.cold, {8'hbb, 2'h1}, "cold");
    chk_val(ntc.cool, {8'ha4, 2'h2}, "cool");
    chk_val(ntc.warm, {8'h54, 2'h1}, "warm");
    chk_val(ntc.hot, {8'h3b, 2'h1}, "hot");
    for (int i = 0; i < 20; i++)
      chk_read(8'h04 + 8'(i), rst_tab[i]);
    $display("test reset done");
    wr(8'h04, 8'h00);
    chk_read(8'h04, 8'h00);
    wr(8'h04, 8'h03);
    chk_read(8'h05, 8'h03);
    wr(8'h05, 8'h00);
    settle();
    chk_val({8'h0, cfg.charge_on, cfg.full_current_when_cool}, 10'h003, "on");
    wr(8'h05, 8'h01);
    chk_read(8'h04, 8'h02);
    wr(8'h05, 8'h02);
    settle();
    chk_val({8'h0, cfg.charge_on, cfg.full_current_when_cool}, 10'h000, "off");
    wr(8'h06, 8'h03);
    chk_read(8'h07, 8'h03);
    settle();
    chk_val({8'h0, cfg.recharge_inhibit, cfg.thermistor_ignore}, 10'h003, "inh");
    wr(8'h07, 8'h02);
    chk_read(8'h06, 8'h01);
    recharge_needed_in = 1'b1;
    wr(8'h04, 8'h01);
    repeat (2) settle();
    chk_val({9'h0, rstart}, 10'h000, "inhibited");
    wr(8'h07, 8'h01);
    repeat (2) settle();
    chk_val({9'h0, rstart}, 10'h001, "recharge");
    recharge_needed_in = 1'b0;
    $display("test set_clear done");
    wr(8'h02, 8'h01);
    chk_val({9'h0, pulse}, 10'h001, "task");
    settle();
    chk_val({9'h0, pulse}, 10'h000, "task end");
    wr(8'h02, 8'h00);
    chk_val({9'h0, pulse}, 10'h000, "task zero");
    chk_read(8'h02, 8'h00);
    $display("test task done");
    for (int c = 0; c < 16; c++) begin
      wr(8'h0c, 8'(c));
      wr(8'h0d, 8'(15 - c));
      settle();
      chk_val({6'h0, cfg.normal_term_voltage}, (c > 13) ? 10'd2 : 10'(c), "vn");
      chk_val({6'h0, cfg.warm_term_voltage}, (c < 2) ? 10'd2 : 10'(15 - c), "vw");
    end
    $display("test vterm done");
    dcode = u_host.discharge_code(800);
    wr(8'h08, 8'h55);
    wr(8'h09, 8'hff);
    wr(8'h0a, dcode[8:1]);
    wr(8'h0b, {7'h0, dcode[0]});
    wr(8'h0e, 8'hff);
    wr(8'h0f, 8'hff);
    wr(8'h30, 8'hff);
    for (int i = 0; i < 8; i++)
      wr(8'h10 + 8'(i), 8'h3c + 8'(i));
    settle();
    chk_val({1'b0, cfg.charge_current_code}, {1'b0, 8'h55, 1'b1}, "ichg");
    chk_val({1'b0, cfg.discharge_limit_code}, 10'h0f8, "idis");
    chk_val({8'h0, cfg.precharge_level, cfg.term_current_level}, 10'h003, "sel");
    chk_val(ntc.cold, {8'h3c, 2'h1}, "cold");
    chk_val(ntc.cool, {8'h3e, 2'h3}, "cool");
    chk_val(ntc.warm, {8'h40, 2'h1}, "warm");
    chk_val(ntc.hot, {8'h42, 2'h3}, "hot");
    chk_read(8'h09, 8'h01);
    chk_read(8'h0e, 8'h01);
    chk_read(8'h13, 8'h03);
    chk_read(8'h30, 8'h00);
    $display("test data done");
    tally_and_finish();
  end
endmodule : tb
